// ---- design/srd_pkg.sv ----
`default_nettype none

package srd_pkg;

	// Operation field of the first byte
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_COMMAND = 2'h2;
	localparam logic [1:0] OP_RESERVED = 2'h3;

	// Direct command codes
	localparam logic [7:0] CMD_HOP_MAIN = 8'h84;
	localparam logic [7:0] CMD_HOP_AUX = 8'h85;
	localparam logic [7:0] CMD_ADC_START = 8'h87;
	localparam logic [7:0] CMD_CAL_START = 8'h88;
	localparam logic [7:0] CMD_CAL_DOWN = 8'h89;
	localparam logic [7:0] CMD_CAL_UP = 8'h8A;
	localparam logic [7:0] CMD_TX_CRC = 8'h90;
	localparam logic [7:0] CMD_TX_CRC_HEADER = 8'h91;
	localparam logic [7:0] CMD_TX_NO_CRC = 8'h92;
	localparam logic [7:0] CMD_RX_BLOCK = 8'h96;
	localparam logic [7:0] CMD_RX_ENABLE = 8'h97;
	localparam logic [7:0] CMD_QUERY = 8'h98;

	// Readable register indexes
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h38;
	localparam logic [5:0] IDX_CAL_VALUE = 6'h39;
	localparam logic [5:0] IDX_BLOCK_STATUS = 6'h3A;

	// Field positions
	localparam int IRQ_CMD_DONE_BIT = 0;
	localparam int IRQ_PARAM_LOST_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RX_EN_BIT = 1;
	localparam int STAT_AUX_BIT = 2;

	// Values after reset and counts
	localparam logic [3:0] CAL_RESET = 4'h8;
	localparam logic [3:0] CAL_MIN = 4'h0;
	localparam logic [3:0] CAL_MAX = 4'hF;
	localparam logic [1:0] QUERY_PARAM_BYTES = 2'h2;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;

	// Transmit flavours
	localparam logic [1:0] TX_MODE_CRC = 2'h0;
	localparam logic [1:0] TX_MODE_CRC_HEADER = 2'h1;
	localparam logic [1:0] TX_MODE_NO_CRC = 2'h2;

	typedef enum logic [1:0] {FRM_FIRST, FRM_READ, FRM_PARAM, FRM_IGNORE} srd_frame_e;
	typedef enum logic {CTL_IDLE, CTL_BUSY} srd_ctl_e;

endpackage

`default_nettype wire

// ---- design/srd_fifo_if.sv ----
`default_nettype none

interface srd_fifo_if #(
	parameter int W = 8
);
	logic [W-1:0] inData;
	logic inValid;
	logic inReady;
	logic [W-1:0] outData;
	logic outValid;
	logic outReady;

	modport fill (output inData, output inValid, input inReady);
	modport store (input inData, input inValid, output inReady,
		output outData, output outValid, input outReady);
	modport drain (input outData, input outValid, output outReady);
endinterface

`default_nettype wire

// ---- design/srd_fifo.sv ----
`default_nettype none

module srd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// System
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Queue ports
	srd_fifo_if.store q
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_reg;
	logic [PW-1:0] rdPtr_reg;
	logic [CW-1:0] count_reg;
	logic [WIDTH-1:0] outData_reg;
	logic outValid_reg;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
		nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign q.inReady = (count_reg != FULL_COUNT);
	assign q.outData = outData_reg;
	assign q.outValid = outValid_reg;
	assign push = q.inValid & q.inReady;
	// Output stage refills whenever it is empty or being taken
	assign pop = (count_reg != '0) & (~outValid_reg | q.outReady);

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_reg <= '0;
		end else if (ce && push) begin
			mem[wrPtr_reg] <= q.inData;
			wrPtr_reg <= nextPtr(wrPtr_reg);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdPtr_reg <= '0;
			outData_reg <= '0;
			outValid_reg <= 1'b0;
		end else if (ce) begin
			if (pop) begin
				outData_reg <= mem[rdPtr_reg];
				outValid_reg <= 1'b1;
				rdPtr_reg <= nextPtr(rdPtr_reg);
			end else if (q.outReady) begin
				outValid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
		end else if (ce) begin
			count_reg <= count_reg + CW'(push) - CW'(pop);
		end
	end
endmodule

`default_nettype wire

// ---- design/srd_spi_slave.sv ----
// Functional notes
// - After mode and address bits of a read, register bytes shift out on MISO.
// - Every MOSI bit is captured on the falling serial clock edge.
// - MISO changes on rising edges; host samples on the next falling edge.
// - Reading an unimplemented address returns an all-zero byte.
// - Direct commands other than Query are one byte; nothing further is expected.
// - Query (98h) takes two parameter bytes which go into the FIFO.
// - First byte with mode bits 1,0 is a direct command; low six bits identify it.
// - A direct command starts at the last falling edge of its byte.
// - Lasting commands keep the block busy until the process reports done.
// - Command completion sets the command-done flag at 38h and raises the interrupt.
// - 84h hops to main frequency; 85h hops to auxiliary frequency.
// - 87h starts an analog-to-digital conversion.
// - 88h starts filter calibration; 89h steps value down, 8Ah steps it up.
// - 90h sends with CRC, 91h with CRC expecting header, 92h without CRC.
// - 96h blocks the receiver; 97h enables it.
// - First two bits pick write, read, command or reserved; MSB first.
// - Multi-byte reads advance the internal address after each data byte.
// - MISO is released except while read data is being driven.
`default_nettype none

module srd_spi_slave (
	// System
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Serial link
	input wire logic sclk,
	input wire logic selN,
	input wire logic mosi,
	output logic misoOut,
	output logic misoOe,
	// Command actions
	output logic hopMain,
	output logic hopAux,
	output logic auxSelected,
	output logic adcStart,
	output logic calStart,
	output logic [3:0] calValue,
	output logic txStart,
	output logic [1:0] txMode,
	output logic rxEnabled,
	output logic queryStart,
	output logic busy,
	// Process completion
	input wire logic procDone,
	// Query parameter stream
	output logic [7:0] paramData,
	output logic paramValid,
	input wire logic paramReady,
	// Interrupt
	output logic irq
);

	// ---------------- Link clock domain ----------------
	srd_pkg::srd_frame_e frame_reg;
	logic [2:0] bitCnt_reg;
	logic [6:0] rxShift_reg;
	logic [7:0] rxByte;
	logic [5:0] addr_reg;
	logic [1:0] paramLeft_reg;
	logic [7:0] cmdByte_reg;
	logic cmdTog_reg;
	logic [7:0] paramByte_reg;
	logic paramTog_reg;
	logic [6:0] txShift_reg;
	logic rdClrTog_reg;
	logic byteEnd;

	// ---------------- System clock domain ----------------
	logic [2:0] cmdSync_reg;
	logic [2:0] paramSync_reg;
	logic [2:0] clrSync_reg;
	logic [1:0] selSync_reg;
	logic [7:0] snapIrq_reg;
	logic [3:0] snapCal_reg;
	logic [7:0] snapStat_reg;
	logic [7:0] irqStatus_reg;
	logic [7:0] irqStatus_next;
	srd_pkg::srd_ctl_e ctl_reg;
	logic cmdEvent;
	logic paramEvent;
	logic clrEvent;
	logic immediateDone;
	logic startsProcess;
	logic procFinished;
	logic pushValid_reg;
	logic [7:0] pushData_reg;
	logic pushBlocked;
	logic lostSet;

	srd_fifo_if #(.W(srd_pkg::FIFO_WIDTH)) paramQ ();

	srd_fifo #(
		.WIDTH(srd_pkg::FIFO_WIDTH),
		.DEPTH(srd_pkg::FIFO_DEPTH)
	) uParamFifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.q(paramQ)
	);

	function automatic logic [7:0] regValue(input logic [5:0] idx, input logic [7:0] irqV,
		input logic [3:0] calV, input logic [7:0] statV);
		case (idx)
			srd_pkg::IDX_IRQ_STATUS: regValue = irqV;
			srd_pkg::IDX_CAL_VALUE: regValue = {4'h0, calV};
			srd_pkg::IDX_BLOCK_STATUS: regValue = statV;
			default: regValue = 8'h00;
		endcase
	endfunction

	function automatic logic cmdHit(input logic ev, input logic [7:0] cmd,
		input logic [7:0] code);
		cmdHit = ev && (cmd == code);
	endfunction

	assign rxByte = {rxShift_reg, mosi};
	assign byteEnd = (bitCnt_reg == srd_pkg::LAST_BIT);

	// Select high ends the frame at once; the serial clock may be stopped by then
	always_ff @(negedge sclk or posedge selN) begin
		if (selN) begin
			bitCnt_reg <= 3'h0;
			rxShift_reg <= 7'h00;
		end else begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
			rxShift_reg <= rxByte[6:0];
		end
	end

	always_ff @(negedge sclk or posedge selN) begin
		if (selN) begin
			frame_reg <= srd_pkg::FRM_FIRST;
		end else if (byteEnd) begin
			unique case (frame_reg)
				srd_pkg::FRM_FIRST: begin
					unique case (rxByte[7:6])
						srd_pkg::OP_READ: frame_reg <= srd_pkg::FRM_READ;
						srd_pkg::OP_COMMAND: begin
							if (rxByte == srd_pkg::CMD_QUERY) begin
								frame_reg <= srd_pkg::FRM_PARAM;
							end else begin
								frame_reg <= srd_pkg::FRM_IGNORE;
							end
						end
						srd_pkg::OP_WRITE: frame_reg <= srd_pkg::FRM_IGNORE;
						srd_pkg::OP_RESERVED: frame_reg <= srd_pkg::FRM_IGNORE;
					endcase
				end
				srd_pkg::FRM_READ: frame_reg <= srd_pkg::FRM_READ;
				srd_pkg::FRM_PARAM: begin
					if (paramLeft_reg == 2'h1) begin
						frame_reg <= srd_pkg::FRM_IGNORE;
					end
				end
				srd_pkg::FRM_IGNORE: frame_reg <= srd_pkg::FRM_IGNORE;
			endcase
		end
	end

	always_ff @(negedge sclk or posedge selN) begin
		if (selN) begin
			addr_reg <= 6'h00;
		end else if (byteEnd && frame_reg == srd_pkg::FRM_FIRST) begin
			addr_reg <= rxByte[5:0];
		end else if (byteEnd && frame_reg == srd_pkg::FRM_READ) begin
			addr_reg <= addr_reg + 6'h01;
		end
	end

	// Toggles survive between frames, so only the system reset clears them
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			cmdTog_reg <= 1'b0;
			cmdByte_reg <= 8'h00;
			paramLeft_reg <= 2'h0;
		end else if (byteEnd && !selN && frame_reg == srd_pkg::FRM_FIRST
			&& rxByte[7:6] == srd_pkg::OP_COMMAND) begin
			cmdByte_reg <= rxByte;
			cmdTog_reg <= ~cmdTog_reg;
			paramLeft_reg <= srd_pkg::QUERY_PARAM_BYTES;
		end else if (byteEnd && !selN && frame_reg == srd_pkg::FRM_PARAM) begin
			paramLeft_reg <= paramLeft_reg - 2'h1;
		end
	end

	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			paramTog_reg <= 1'b0;
			paramByte_reg <= 8'h00;
		end else if (byteEnd && !selN && frame_reg == srd_pkg::FRM_PARAM) begin
			paramByte_reg <= rxByte;
			paramTog_reg <= ~paramTog_reg;
		end
	end

	always_ff @(posedge sclk or posedge selN) begin
		if (selN) begin
			misoOe <= 1'b0;
			misoOut <= 1'b0;
			txShift_reg <= 7'h00;
		end else if (frame_reg == srd_pkg::FRM_READ && bitCnt_reg == 3'h0) begin
			{misoOut, txShift_reg} <= regValue(addr_reg, snapIrq_reg, snapCal_reg,
				snapStat_reg);
			misoOe <= 1'b1;
		end else begin
			{misoOut, txShift_reg} <= {txShift_reg, 1'b0};
		end
	end

	// Reading the status register clears what was read
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			rdClrTog_reg <= 1'b0;
		end else if (!selN && frame_reg == srd_pkg::FRM_READ && bitCnt_reg == 3'h0
			&& addr_reg == srd_pkg::IDX_IRQ_STATUS) begin
			rdClrTog_reg <= ~rdClrTog_reg;
		end
	end

	// ---------------- Crossings into the system clock ----------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cmdSync_reg <= 3'h0;
			paramSync_reg <= 3'h0;
			clrSync_reg <= 3'h0;
			selSync_reg <= 2'h3;
		end else if (ce) begin
			cmdSync_reg <= {cmdSync_reg[1:0], cmdTog_reg};
			paramSync_reg <= {paramSync_reg[1:0], paramTog_reg};
			clrSync_reg <= {clrSync_reg[1:0], rdClrTog_reg};
			selSync_reg <= {selSync_reg[0], selN};
		end
	end

	assign cmdEvent = cmdSync_reg[2] ^ cmdSync_reg[1];
	assign paramEvent = paramSync_reg[2] ^ paramSync_reg[1];
	assign clrEvent = clrSync_reg[2] ^ clrSync_reg[1];

	// Snapshot frozen while selected; the link reads it without a handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			snapIrq_reg <= 8'h00;
			snapCal_reg <= srd_pkg::CAL_RESET;
			snapStat_reg <= 8'h00;
		end else if (ce && selSync_reg[1]) begin
			snapIrq_reg <= irqStatus_reg;
			snapCal_reg <= calValue;
			snapStat_reg <= 8'h00;
			snapStat_reg[srd_pkg::STAT_BUSY_BIT] <= busy;
			snapStat_reg[srd_pkg::STAT_RX_EN_BIT] <= rxEnabled;
			snapStat_reg[srd_pkg::STAT_AUX_BIT] <= auxSelected;
		end
	end

	// ---------------- Command execution ----------------
	always_comb begin
		immediateDone = 1'b0;
		startsProcess = 1'b0;
		if (cmdEvent) begin
			case (cmdByte_reg)
				srd_pkg::CMD_HOP_MAIN,
				srd_pkg::CMD_HOP_AUX,
				srd_pkg::CMD_CAL_DOWN,
				srd_pkg::CMD_CAL_UP,
				srd_pkg::CMD_RX_BLOCK,
				srd_pkg::CMD_RX_ENABLE: immediateDone = 1'b1;
				srd_pkg::CMD_ADC_START,
				srd_pkg::CMD_CAL_START,
				srd_pkg::CMD_TX_CRC,
				srd_pkg::CMD_TX_CRC_HEADER,
				srd_pkg::CMD_TX_NO_CRC,
				srd_pkg::CMD_QUERY: startsProcess = 1'b1;
				default: ;
			endcase
		end
	end

	assign procFinished = (ctl_reg == srd_pkg::CTL_BUSY) && procDone;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_reg <= srd_pkg::CTL_IDLE;
			busy <= 1'b0;
		end else if (ce) begin
			unique case (ctl_reg)
				srd_pkg::CTL_IDLE: begin
					if (startsProcess) begin
						ctl_reg <= srd_pkg::CTL_BUSY;
						busy <= 1'b1;
					end
				end
				srd_pkg::CTL_BUSY: begin
					if (procDone && !startsProcess) begin
						ctl_reg <= srd_pkg::CTL_IDLE;
						busy <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hopMain <= 1'b0;
			hopAux <= 1'b0;
			adcStart <= 1'b0;
			calStart <= 1'b0;
			txStart <= 1'b0;
			queryStart <= 1'b0;
		end else if (ce) begin
			hopMain <= cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_HOP_MAIN);
			hopAux <= cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_HOP_AUX);
			adcStart <= cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_ADC_START);
			calStart <= cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_CAL_START);
			txStart <= cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_TX_CRC)
				| cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_TX_CRC_HEADER)
				| cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_TX_NO_CRC);
			queryStart <= cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_QUERY);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			auxSelected <= 1'b0;
			rxEnabled <= 1'b0;
			txMode <= srd_pkg::TX_MODE_CRC;
		end else if (ce) begin
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_HOP_MAIN)) begin
				auxSelected <= 1'b0;
			end
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_HOP_AUX)) begin
				auxSelected <= 1'b1;
			end
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_RX_BLOCK)) begin
				rxEnabled <= 1'b0;
			end
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_RX_ENABLE)) begin
				rxEnabled <= 1'b1;
			end
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_TX_CRC)) begin
				txMode <= srd_pkg::TX_MODE_CRC;
			end
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_TX_CRC_HEADER)) begin
				txMode <= srd_pkg::TX_MODE_CRC_HEADER;
			end
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_TX_NO_CRC)) begin
				txMode <= srd_pkg::TX_MODE_NO_CRC;
			end
		end
	end

	// Steps saturate so a run of presses cannot wrap the filter setting
	always_ff @(posedge clk) begin
		if (rst) begin
			calValue <= srd_pkg::CAL_RESET;
		end else if (ce) begin
			if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_CAL_DOWN)
				&& calValue != srd_pkg::CAL_MIN) begin
				calValue <= calValue - 4'h1;
			end else if (cmdHit(cmdEvent, cmdByte_reg, srd_pkg::CMD_CAL_UP)
				&& calValue != srd_pkg::CAL_MAX) begin
				calValue <= calValue + 4'h1;
			end
		end
	end

	// ---------------- Query parameters into the FIFO ----------------
	assign pushBlocked = pushValid_reg & ~paramQ.inReady;
	assign lostSet = paramEvent & pushBlocked;
	assign paramQ.inData = pushData_reg;
	assign paramQ.inValid = pushValid_reg;
	assign paramQ.outReady = paramReady;
	assign paramData = paramQ.outData;
	assign paramValid = paramQ.outValid;

	// A full FIFO holds the pending byte; a byte arriving meanwhile is dropped and flagged
	always_ff @(posedge clk) begin
		if (rst) begin
			pushValid_reg <= 1'b0;
			pushData_reg <= 8'h00;
		end else if (ce) begin
			if (paramEvent && !pushBlocked) begin
				pushData_reg <= paramByte_reg;
				pushValid_reg <= 1'b1;
			end else if (paramQ.inReady) begin
				pushValid_reg <= 1'b0;
			end
		end
	end

	// ---------------- Interrupt status ----------------
	always_comb begin
		irqStatus_next = irqStatus_reg;
		if (clrEvent) begin
			irqStatus_next = irqStatus_reg & ~snapIrq_reg;
		end
		if (immediateDone || procFinished) begin
			irqStatus_next[srd_pkg::IRQ_CMD_DONE_BIT] = 1'b1;
		end
		if (lostSet) begin
			irqStatus_next[srd_pkg::IRQ_PARAM_LOST_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatus_reg <= 8'h00;
			irq <= 1'b0;
		end else if (ce) begin
			irqStatus_reg <= irqStatus_next;
			irq <= |irqStatus_next;
		end
	end
endmodule

`default_nettype wire

// ---- verif/srd_spi_monitor.sv ----
`default_nettype none

module srd_spi_monitor (
	// System
	input wire logic clk,
	input wire logic rst,
	// Link
	input wire logic selN,
	input wire logic misoOut,
	input wire logic misoOe,
	// Actions
	input wire logic hopMain,
	input wire logic hopAux,
	input wire logic auxSelected,
	input wire logic adcStart,
	input wire logic calStart,
	input wire logic [3:0] calValue,
	input wire logic txStart,
	input wire logic [1:0] txMode,
	input wire logic queryStart,
	input wire logic busy,
	input wire logic procDone,
	// Stream and interrupt
	input wire logic [7:0] paramData,
	input wire logic paramValid,
	input wire logic paramReady,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence sLasting;
		adcStart || calStart || txStart || queryStart;
	endsequence
	sequence sFinish;
		busy && procDone;
	endsequence
	AST_LASTING_BUSY: assert property (sLasting |-> ##[0:1] busy)
		else $error("lasting command left busy low");
	AST_DONE_IRQ: assert property (sFinish |=> !busy && irq)
		else $error("process end did not flag completion");
	AST_IMM_IRQ: assert property ((hopMain || hopAux) |-> irq)
		else $error("immediate command raised no interrupt");
	AST_HOP_MAIN: assert property (hopMain |=> !auxSelected)
		else $error("main hop left auxiliary selected");
	AST_HOP_AUX: assert property (hopAux |=> auxSelected)
		else $error("auxiliary hop not taken");
	AST_CAL_STEP: assert property ($changed(calValue) |->
		calValue == $past(calValue) + 4'h1 || calValue == $past(calValue) - 4'h1)
		else $error("calibration moved by more than one step");
	AST_TX_MODE: assert property (txStart |-> txMode != 2'h3)
		else $error("transmit started with no valid flavour");
	AST_ONE_ACTION: assert property ($onehot0({hopMain, hopAux, adcStart, calStart,
		txStart, queryStart}))
		else $error("one command byte gave two actions");
	AST_OE_IDLE: assert property (selN && $past(selN) |-> !misoOe && !misoOut)
		else $error("serial output driven outside a frame");
	AST_PARAM_HOLD: assert property (paramValid && !paramReady |=>
		paramValid && $stable(paramData))
		else $error("parameter byte changed while stalled");
endmodule

bind srd_spi_slave srd_spi_monitor u_mon (.clk(clk), .rst(rst), .selN(selN),
	.misoOut(misoOut), .misoOe(misoOe), .hopMain(hopMain), .hopAux(hopAux),
	.auxSelected(auxSelected), .adcStart(adcStart), .calStart(calStart), .calValue(calValue),
	.txStart(txStart), .txMode(txMode), .queryStart(queryStart), .busy(busy),
	.procDone(procDone), .paramData(paramData), .paramValid(paramValid),
	.paramReady(paramReady), .irq(irq));

`default_nettype wire

// ---- verif/srd_host_model.sv ----
`default_nettype none

module srd_host_model (
	// Serial link
	output logic sclk,
	output logic selN,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b0;
		selN = 1'b0;
		mosi = 1'b0;
		// A real rising select clears the link-side frame state before any frame
		#1 selN = 1'b1;
	end
	// Long lead so the device freezes its register snapshot first
	task automatic open();
		#7 selN = 1'b0;
		#200;
	endtask
	task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
		int i;
		for (i = 7; i >= 0; i--) begin
			#8 mosi = d[i];
			#24 sclk = 1'b1;
			#32 r[i] = miso;
			sclk = 1'b0;
		end
	endtask
	// Clock stands still between frames; data line shows a changed level
	task automatic close();
		#40 selN = 1'b1;
		mosi = ~mosi;
		#300;
	endtask
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst = 1'b0, ce = 1'b1, procDone = 1'b0, paramReady = 1'b0;
	logic sclk, selN, mosi, miso, misoOut, misoOe, hopMain, hopAux, auxSelected, adcStart;
	logic calStart, txStart, rxEnabled, queryStart, busy, paramValid, irq;
	logic [3:0] calValue;
	logic [1:0] txMode;
	logic [7:0] paramData, seenByte, r;
	logic [7:0] expQ[$], parQ[$];
	logic aux = 1'b0, rx = 1'b0, known;
	logic [5:0] lastAct = 6'h00;
	logic [3:0] cal = srd_pkg::CAL_RESET;
	logic [7:0] immCodes[16] = '{8'h97, 8'h85, 8'h8A, 8'h89, 8'h96, 8'h84, 8'h99, 8'hBF,
		8'h8A, 8'h8A, 8'h8A, 8'h8A, 8'h8A, 8'h8A, 8'h8A, 8'h8A};
	logic [7:0] lastCodes[5] = '{8'h87, 8'h88, 8'h90, 8'h91, 8'h92};
	int mismatches = 0, compares = 0, seed, i, nAct = 0;
	event got;

	assign miso = misoOe ? misoOut : 1'bz;

	srd_spi_slave dut (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .selN(selN), .mosi(mosi),
		.misoOut(misoOut), .misoOe(misoOe), .hopMain(hopMain), .hopAux(hopAux),
		.auxSelected(auxSelected), .adcStart(adcStart), .calStart(calStart),
		.calValue(calValue), .txStart(txStart), .txMode(txMode), .rxEnabled(rxEnabled),
		.queryStart(queryStart), .busy(busy), .procDone(procDone), .paramData(paramData),
		.paramValid(paramValid), .paramReady(paramReady), .irq(irq));
	srd_host_model host (.sclk(sclk), .selN(selN), .mosi(mosi), .miso(miso));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] pop(ref logic [7:0] q[$]);
		if (q.size() == 0) return 8'hXX;
		return q.pop_front();
	endfunction
	task automatic results();
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Result watchers
	always @(got) check(seenByte, pop(expQ));
	always @(posedge clk) begin
		if (!rst && ce === 1'b1 && paramValid === 1'b1 && paramReady === 1'b1) begin
			check(paramData, pop(parQ));
		end
	end
	// Action pulses last one cycle, so they are caught here and compared later
	always @(posedge clk) begin
		if (hopMain | hopAux | adcStart | calStart | txStart | queryStart) begin
			lastAct <= {hopMain, hopAux, adcStart, calStart, txStart, queryStart};
			nAct <= nAct + 1;
		end
	end
	function automatic logic [7:0] actOf(input logic [7:0] c);
		case (c)
			srd_pkg::CMD_HOP_MAIN: return 8'h20;
			srd_pkg::CMD_HOP_AUX: return 8'h10;
			srd_pkg::CMD_ADC_START: return 8'h08;
			srd_pkg::CMD_CAL_START: return 8'h04;
			srd_pkg::CMD_QUERY: return 8'h01;
			default: return 8'h02;
		endcase
	endfunction

	task automatic rd(input logic [5:0] a, input int n);
		host.open();
		host.xbyte({srd_pkg::OP_READ, a}, r);
		repeat (n) begin
			host.xbyte(8'h00, r);
			seenByte = r;
			-> got;
		end
		host.close();
		repeat (4) @(posedge clk);
	endtask
	// 18 bytes fit: sixteen stored, one at the output, one pending; later ones are lost
	task automatic cmd(input logic [7:0] c, input int nPar);
		logic [7:0] p;
		host.open();
		host.xbyte(c, r);
		repeat (nPar) begin
			p = 8'($random(seed));
			if (parQ.size() < 18) parQ.push_back(p);
			host.xbyte(p, r);
		end
		host.close();
		repeat (4) @(posedge clk);
	endtask
	task automatic finish();
		@(posedge clk) procDone <= 1'b1;
		@(posedge clk) procDone <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic imm(input logic [7:0] c);
		known = 1'b1;
		cmd(c, 0);
		if (c == srd_pkg::CMD_HOP_MAIN || c == srd_pkg::CMD_HOP_AUX) begin
			check({2'h0, lastAct}, actOf(c));
		end
		case (c)
			srd_pkg::CMD_RX_ENABLE: rx = 1'b1;
			srd_pkg::CMD_RX_BLOCK: rx = 1'b0;
			srd_pkg::CMD_HOP_AUX: aux = 1'b1;
			srd_pkg::CMD_HOP_MAIN: aux = 1'b0;
			srd_pkg::CMD_CAL_UP: if (cal != 4'hF) cal = cal + 4'h1;
			srd_pkg::CMD_CAL_DOWN: if (cal != 4'h0) cal = cal - 4'h1;
			default: known = 1'b0;
		endcase
		check({2'h0, auxSelected, rxEnabled, calValue}, {2'h0, aux, rx, cal});
		check(irq, known);
		expQ.push_back({7'h0, known});
		rd(srd_pkg::IDX_IRQ_STATUS, 1);
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		results();
	end

	initial begin
		// Raised by non-blocking assignment so the link-side reset sees a real edge
		rst <= 1'b1;
		seed = 32'hF96106D4;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		expQ = '{8'h00, {4'h0, srd_pkg::CAL_RESET}, 8'h00, 8'h00};
		rd(srd_pkg::IDX_IRQ_STATUS, 4);
		foreach (lastCodes[i]) begin
			host.open();
			host.xbyte({i[0] ? srd_pkg::OP_RESERVED : srd_pkg::OP_WRITE, 6'h39}, r);
			host.xbyte(8'h03, r);
			host.close();
		end
		expQ.push_back({4'h0, srd_pkg::CAL_RESET});
		rd(srd_pkg::IDX_CAL_VALUE, 1);
		foreach (immCodes[i]) imm(immCodes[i]);
		foreach (lastCodes[i]) begin
			cmd(lastCodes[i], 0);
			check(busy, 1'b1);
			check({2'h0, lastAct}, actOf(lastCodes[i]));
			if (lastCodes[i][4]) check(txMode, lastCodes[i][1:0]);
			finish();
			check(irq, 1'b1);
			expQ.push_back(8'h01);
			rd(srd_pkg::IDX_IRQ_STATUS, 1);
		end
		// Consumer stalls while ten queries overfill the parameter queue by two bytes
		for (i = 0; i < 10; i++) begin
			cmd(srd_pkg::CMD_QUERY, 2);
			check({2'h0, lastAct}, actOf(srd_pkg::CMD_QUERY));
			finish();
		end
		expQ.push_back(8'h03);
		rd(srd_pkg::IDX_IRQ_STATUS, 1);
		// A random clock enable must hold the queue still while low
		for (i = 0; i < 2000 && parQ.size() > 0; i++) begin
			@(posedge clk);
			paramReady <= 1'($random(seed));
			ce <= 1'($random(seed));
		end
		@(posedge clk);
		paramReady <= 1'b0;
		ce <= 1'b1;
		if (parQ.size() > 0) mismatches++;
		repeat (4) @(posedge clk);
		check(paramValid, 1'b0);
		// Two hops, five lasting commands and ten queries pulse once each
		check(8'(nAct), 8'h11);
		results();
	end
endmodule

`default_nettype wire
